// >>> design/acrb_regs.sv
// control register bank of the eight-channel converter
//
// Operation
// - only offsets 0x00 to 0x0a are functional
// - offset 0x00 reads part id and revision
// - straps rule until control port enable set
// - ratio bit divides master clock by 1.5
// - ratio and divider bits give composite divider
// - format field picks left-justified, i2s, tdm
// - mode field picks speed and master/slave
// - overflow drives status bit and pin low
// - status bit sticky until status read
// - mask bit low keeps channel off pin
// - per-channel high-pass disable, resets enabled
// - disabling high-pass freezes the dc estimate
// - power-down bit 5 stops bandgap
// - power-down bit 4 stops the core clock, not the pair clocks
// - pair power-down stops clocks, zeros data
// - mute bit zeros that channel's samples
// - tristate bits float serial data pins
// - pointer selects register, optional auto-increment
`include "acrb_consts.svh"

module acrb_regs #(
	parameter logic [3:0] PART_ID  = 4'h5, // arbitrary value
	parameter logic [3:0] REVISION = 4'h3  // arbitrary value
) (
	input  wire logic                    ref_clk,     // 200 mhz core clock
	input  wire logic                    rst,         // synchronous reset
	input  wire acrb_pkg::acrb_host_req_t host_req,   // byte strobes from port engine
	output logic      [7:0]              rd_data,     // byte fetched by host
	output logic                         rd_valid,    // rd_data fresh
	input  wire acrb_pkg::acrb_strap_t    strap,      // stand-alone pins
	input  wire logic [7:0]              ovf_event,   // per-channel overflow
	output acrb_pkg::acrb_cfg_t          cfg,         // effective clocking and format
	output logic                         cp_mode,     // registers in charge
	output logic                         overflow_status_pin_o,  // open-drain level, always low
	output logic                         overflow_status_pin_oe, // pulls overflow pin low
	output logic                         bandgap_pd,  // bandgap powered down
	output logic                         core_clk_en, // internal clock allowed
	output logic      [3:0]              pair_clk_en, // clocks per channel pair
	output logic      [7:0]              chan_zero,   // force channel samples to zero
	output logic      [7:0]              hpf_freeze,  // hold dc offset estimate
	output logic      [3:0]              serial_data_output_oe     // serial data pin driven
);
	import acrb_pkg::*;

	// ********************************
	// storage
	// ********************************
	logic [6:0]  ptr;
	logic        ptr_pointer_auto_increment;
	logic [7:0]  global_control;
	logic [7:0]  overflow_mask;
	logic [7:0]  highpass_disable;
	logic [7:0]  power_down;
	logic [7:0]  channel_mute;
	logic [7:0]  serial_output_tristate;
	logic [7:0]  overflow_status;
	logic [7:0]  next_rd_data;
	logic        wr_hit;
	logic        rd_hit;
	logic        stat_clear;
	acrb_strap_t strap_sync;
	acrb_strap_t cfg_src;
	acrb_cfg_t   next_cfg;
	logic        control_port_enable;

	// ********************************
	// host strobes
	// ********************************
	// pointer load takes priority over any data strobe in the same cycle
	assign wr_hit = host_req.data_wr & ~host_req.map_wr;
	assign rd_hit = host_req.data_rd & ~host_req.map_wr & ~host_req.data_wr;
	assign control_port_enable  = global_control[`ACRB_POS_CONTROL_PORT_ENABLE];

	// address pointer with optional advance after each data byte
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ptr      <= `ACRB_RST_PTR;
			ptr_pointer_auto_increment <= 1'b0;
		end else if (host_req.map_wr) begin
			ptr      <= host_req.wdata[6:0];
			ptr_pointer_auto_increment <= host_req.wdata[`ACRB_POS_PTR_POINTER_AUTO_INCREMENT];
		end else if ((wr_hit | rd_hit) && ptr_pointer_auto_increment) begin
			ptr <= ptr + 7'h01;
		end
	end

	// ********************************
	// writable registers
	// ********************************
	// global control, only this one decides who owns the config
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			global_control <= `ACRB_RST_GLOBAL;
		end else if (wr_hit && ptr == `ACRB_OFS_GLOBAL) begin
			global_control <= host_req.wdata;
		end
	end

	// overflow mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			overflow_mask <= `ACRB_RST_OVF_MASK;
		end else if (wr_hit && ptr == `ACRB_OFS_OVF_MASK) begin
			overflow_mask <= host_req.wdata;
		end
	end

	// high-pass disable, bit n-1 for channel n
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			highpass_disable <= `ACRB_RST_HPF_DIS;
		end else if (wr_hit && ptr == `ACRB_OFS_HPF_DIS) begin
			highpass_disable <= host_req.wdata;
		end
	end

	// power down, top two bits never stored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			power_down <= `ACRB_RST_PWR_DOWN;
		end else if (wr_hit && ptr == `ACRB_OFS_PWR_DOWN) begin
			power_down <= host_req.wdata & `ACRB_MSK_PWR_DOWN;
		end
	end

	// channel mute
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			channel_mute <= `ACRB_RST_MUTE;
		end else if (wr_hit && ptr == `ACRB_OFS_MUTE) begin
			channel_mute <= host_req.wdata;
		end
	end

	// serial output tristate, upper nibble never stored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serial_output_tristate <= `ACRB_RST_SD_TRI;
		end else if (wr_hit && ptr == `ACRB_OFS_SD_TRI) begin
			serial_output_tristate <= host_req.wdata & `ACRB_MSK_SD_TRI;
		end
	end

	// ********************************
	// overflow status
	// ********************************
	// the read that returns the status also clears it
	assign stat_clear = rd_hit && (ptr == `ACRB_OFS_OVF_STAT);

	// one sticky cell per channel
	for (genvar ch = 0; ch < 8; ch++) begin : g_ovf
		acrb_ovf_flag u_flag (
			.ref_clk (ref_clk),
			.rst     (rst),
			.event_i (ovf_event[ch]),
			.clear   (stat_clear),
			.flag_n  (overflow_status[ch])
		);
	end

	// open-drain pin, driven low while any unmasked flag is held
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			overflow_status_pin_o  <= 1'b0;
			overflow_status_pin_oe <= 1'b0;
		end else begin
			overflow_status_pin_o  <= 1'b0;
			overflow_status_pin_oe <= |(~overflow_status & overflow_mask);
		end
	end

	// ********************************
	// read path
	// ********************************
	// reserved and unmapped offsets fall through to zero
	always_comb begin
		next_rd_data = 8'h00;
		if (ptr == `ACRB_OFS_IDENT) begin
			next_rd_data = {PART_ID, REVISION};
		end else if (ptr == `ACRB_OFS_GLOBAL) begin
			next_rd_data = global_control;
		end else if (ptr == `ACRB_OFS_OVF_STAT) begin
			next_rd_data = overflow_status;
		end else if (ptr == `ACRB_OFS_OVF_MASK) begin
			next_rd_data = overflow_mask;
		end else if (ptr == `ACRB_OFS_HPF_DIS) begin
			next_rd_data = highpass_disable;
		end else if (ptr == `ACRB_OFS_PWR_DOWN) begin
			next_rd_data = power_down;
		end else if (ptr == `ACRB_OFS_MUTE) begin
			next_rd_data = channel_mute;
		end else if (ptr == `ACRB_OFS_SD_TRI) begin
			next_rd_data = serial_output_tristate;
		end else if (ptr > `ACRB_OFS_SD_TRI) begin
			next_rd_data = 8'h00;
		end
	end

	// read data registered, valid one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_hit;
			if (rd_hit) begin
				rd_data <= next_rd_data;
			end
		end
	end

	// ********************************
	// configuration source
	// ********************************
	// pins are synchronised even while ignored, so handover is glitch free
	acrb_pin_sync #(
		.W ($bits(acrb_strap_t))
	) u_strap_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (strap),
		.q       (strap_sync)
	);

	// pick straps or register fields
	always_comb begin
		if (control_port_enable) begin
			cfg_src.clock_ratio_select   = global_control[`ACRB_POS_RATIO];
			cfg_src.master_clock_divider =
				global_control[`ACRB_POS_MDIV_HI:`ACRB_POS_MDIV_LO];
			cfg_src.serial_format_select =
				global_control[`ACRB_POS_FMT_HI:`ACRB_POS_FMT_LO];
			cfg_src.mode = global_control[`ACRB_POS_MODE_HI:`ACRB_POS_MODE_LO];
		end else begin
			cfg_src = strap_sync;
		end
	end

	// decode the composite divider and the modes
	always_comb begin
		next_cfg.fmt       = acrb_fmt_t'(cfg_src.serial_format_select);
		next_cfg.mode      = acrb_mode_t'(cfg_src.mode);
		next_cfg.ratio_384 = cfg_src.clock_ratio_select;
		case ({cfg_src.clock_ratio_select, cfg_src.master_clock_divider})
			3'b000: begin
				next_cfg.div = ACRB_DIV_1;
			end
			3'b100: begin
				next_cfg.div = ACRB_DIV_1P5;
			end
			3'b001, 3'b010: begin
				next_cfg.div = ACRB_DIV_2;
			end
			3'b101, 3'b110: begin
				next_cfg.div = ACRB_DIV_3;
			end
			3'b011: begin
				next_cfg.div = ACRB_DIV_4;
			end
			default: begin
				next_cfg.div = ACRB_DIV_RSVD;
			end
		endcase
	end

	// effective config registered
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg     <= '0;
			cp_mode <= 1'b0;
		end else begin
			cfg     <= next_cfg;
			cp_mode <= control_port_enable;
		end
	end

	// ********************************
	// power, mute, filter and pin controls
	// ********************************
	// stand-alone mode keeps everything powered, unmuted and filtering
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bandgap_pd  <= 1'b0;
			core_clk_en <= 1'b1;
			pair_clk_en <= 4'hf;
		end else if (control_port_enable) begin
			bandgap_pd  <= power_down[`ACRB_POS_BG_PD];
			core_clk_en <= ~power_down[`ACRB_POS_OSC_PD];
			pair_clk_en <= ~power_down[`ACRB_POS_PAIR_HI:`ACRB_POS_PAIR_LO];
		end else begin
			bandgap_pd  <= 1'b0;
			core_clk_en <= 1'b1;
			pair_clk_en <= 4'hf;
		end
	end

	// a powered-down pair zeros both of its channels as well
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chan_zero <= 8'h00;
		end else if (control_port_enable) begin
			for (int ch = 0; ch < 8; ch++) begin
				chan_zero[ch] <= channel_mute[ch] | power_down[ch/2];
			end
		end else begin
			chan_zero <= 8'h00;
		end
	end

	// freezing holds the estimate, the filter keeps subtracting it downstream
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hpf_freeze <= 8'h00;
		end else if (control_port_enable) begin
			hpf_freeze <= highpass_disable;
		end else begin
			hpf_freeze <= 8'h00;
		end
	end

	// tristate bit set floats the matching pin
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serial_data_output_oe <= 4'hf;
		end else if (control_port_enable) begin
			serial_data_output_oe <= ~serial_output_tristate[3:0];
		end else begin
			serial_data_output_oe <= 4'hf;
		end
	end
endmodule

// >>> design/acrb_consts.svh
// register offsets, field positions and reset values of the converter control bank
`ifndef ACRB_CONSTS_SVH
`define ACRB_CONSTS_SVH

// ********************************
// register offsets
// ********************************
`define ACRB_OFS_IDENT     7'h00
`define ACRB_OFS_GLOBAL    7'h01
`define ACRB_OFS_OVF_STAT  7'h02
`define ACRB_OFS_OVF_MASK  7'h03
`define ACRB_OFS_HPF_DIS   7'h04
`define ACRB_OFS_RSVD_A    7'h05
`define ACRB_OFS_PWR_DOWN  7'h06
`define ACRB_OFS_RSVD_B    7'h07
`define ACRB_OFS_MUTE      7'h08
`define ACRB_OFS_RSVD_C    7'h09
`define ACRB_OFS_SD_TRI    7'h0a

// ********************************
// field positions
// ********************************
`define ACRB_POS_PTR_POINTER_AUTO_INCREMENT  7
`define ACRB_POS_CONTROL_PORT_ENABLE     7
`define ACRB_POS_RATIO     6
`define ACRB_POS_MDIV_HI   5
`define ACRB_POS_MDIV_LO   4
`define ACRB_POS_FMT_HI    3
`define ACRB_POS_FMT_LO    2
`define ACRB_POS_MODE_HI   1
`define ACRB_POS_MODE_LO   0
`define ACRB_POS_ID_HI     7
`define ACRB_POS_ID_LO     4
`define ACRB_POS_BG_PD     5
`define ACRB_POS_OSC_PD    4
`define ACRB_POS_PAIR_HI   3
`define ACRB_POS_PAIR_LO   0

// ********************************
// reset values and writable masks
// ********************************
`define ACRB_RST_GLOBAL    8'h00
`define ACRB_RST_OVF_STAT  8'hff
`define ACRB_RST_OVF_MASK  8'hff
`define ACRB_RST_HPF_DIS   8'h00
`define ACRB_RST_PWR_DOWN  8'h00
`define ACRB_RST_MUTE      8'h00
`define ACRB_RST_SD_TRI    8'h00
`define ACRB_MSK_PWR_DOWN  8'h3f
`define ACRB_MSK_SD_TRI    8'h0f
`define ACRB_RST_PTR       7'h00

`endif

// >>> design/acrb_pkg.sv
// types shared by the converter control bank modules
package acrb_pkg;

	// ********************************
	// modes and encodings
	// ********************************
	typedef enum logic [1:0] {
		ACRB_FMT_LEFT_JUST,
		ACRB_FMT_I2S,
		ACRB_FMT_TDM,
		ACRB_FMT_RSVD
	} acrb_fmt_t;

	typedef enum logic [1:0] {
		ACRB_MODE_SINGLE_MASTER,
		ACRB_MODE_DOUBLE_MASTER,
		ACRB_MODE_QUAD_MASTER,
		ACRB_MODE_SLAVE
	} acrb_mode_t;

	typedef enum logic [2:0] {
		ACRB_DIV_1,
		ACRB_DIV_1P5,
		ACRB_DIV_2,
		ACRB_DIV_3,
		ACRB_DIV_4,
		ACRB_DIV_RSVD
	} acrb_div_t;

	// ********************************
	// carriers
	// ********************************
	typedef struct packed {
		logic       map_wr;   // byte is the address pointer
		logic       data_wr;  // byte is register data
		logic       data_rd;  // host fetches one byte
		logic [7:0] wdata;
	} acrb_host_req_t;

	typedef struct packed {
		logic       clock_ratio_select;
		logic [1:0] master_clock_divider;
		logic [1:0] serial_format_select;
		logic [1:0] mode;
	} acrb_strap_t;

	typedef struct packed {
		acrb_fmt_t  fmt;
		acrb_mode_t mode;
		acrb_div_t  div;
		logic       ratio_384;
	} acrb_cfg_t;

endpackage

// >>> design/acrb_pin_sync.sv
// three-stage pin synchroniser, output follows once stages two and three agree
module acrb_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk, // core clock
	input  wire logic         rst,     // synchronous reset
	input  wire logic [W-1:0] pin,     // asynchronous pin level
	output logic      [W-1:0] q        // settled level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// s1 feeds only s2 to keep metastability out of the compare
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// bitwise agreement filter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					q[i] <= s3[i];
				end
			end
		end
	end
endmodule

// >>> design/acrb_ovf_flag.sv
// one sticky active-low overflow flag, cleared by a read of the status register
module acrb_ovf_flag (
	input  wire logic ref_clk, // core clock
	input  wire logic rst,     // synchronous reset
	input  wire logic event_i, // overflow seen this cycle
	input  wire logic clear,   // status register read
	output logic      flag_n   // low while overflow held
);
	// a new event beats a clear in the same cycle so nothing is lost
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flag_n <= 1'b1;
		end else if (event_i) begin
			flag_n <= 1'b0;
		end else if (clear) begin
			flag_n <= 1'b1;
		end
	end
endmodule

// >>> bench/acrb_regs_props.sv
// port-level checks of the converter control bank
module acrb_regs_props
	import acrb_pkg::*;
#(
	parameter logic [3:0] PART_ID  = 4'h5, // arbitrary value
	parameter logic [3:0] REVISION = 4'h3  // arbitrary value
) (
	input wire logic                     ref_clk,     // core clock
	input wire logic                     rst,         // sync reset
	input wire acrb_pkg::acrb_host_req_t host_req,    // byte strobes
	input wire logic [7:0]               rd_data,     // read byte
	input wire logic                     rd_valid,    // read answer
	input wire acrb_pkg::acrb_strap_t    strap,       // strap pins
	input wire logic [7:0]               ovf_event,   // overflows
	input wire acrb_pkg::acrb_cfg_t      cfg,         // effective config
	input wire logic                     cp_mode,     // registers rule
	input wire logic                     overflow_status_pin_o,  // pin level
	input wire logic                     overflow_status_pin_oe, // pin pulled
	input wire logic                     bandgap_pd,  // bandgap off
	input wire logic                     core_clk_en, // clocks run
	input wire logic [3:0]               pair_clk_en, // pair clocks
	input wire logic [7:0]               chan_zero,   // zeroed channels
	input wire logic [7:0]               hpf_freeze,  // frozen estimates
	input wire logic [3:0]               serial_data_output_oe     // pins driven
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam acrb_div_t DIVS [8] = '{ACRB_DIV_1, ACRB_DIV_2, ACRB_DIV_2, ACRB_DIV_4,
		ACRB_DIV_1P5, ACRB_DIV_3, ACRB_DIV_3, ACRB_DIV_RSVD};
	logic [6:0] ptr;
	logic       pointer_auto_increment;
	logic [7:0] mask;
	wire logic  wr_tk = host_req.data_wr & ~host_req.map_wr;
	wire logic  rd_tk = host_req.data_rd & ~host_req.map_wr & ~host_req.data_wr;
	// shadow pointer, so a read can be tied to the place it hits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ptr  <= 7'h00;
			pointer_auto_increment <= 1'b0;
		end else if (host_req.map_wr) begin
			ptr  <= host_req.wdata[6:0];
			pointer_auto_increment <= host_req.wdata[7];
		end else if ((wr_tk || rd_tk) && pointer_auto_increment) begin
			ptr <= ptr + 7'h01;
		end
	end
	// shadow mask, only for the pin check
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mask <= 8'hff;
		end else if (wr_tk && ptr == 7'h03) begin
			mask <= host_req.wdata;
		end
	end
	// ****************
	// properties
	// ****************
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_rd_answer; rd_tk |=> rd_valid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered next cycle");
	property p_rd_only; !$past(rd_tk) |-> !rd_valid; endproperty
	a_rd_only: assert property (p_rd_only)
		else $error("read answer without a read");
	property p_ident; rd_tk && ptr == 7'h00 |=> rd_data == {PART_ID, REVISION}; endproperty
	a_ident: assert property (p_ident)
		else $error("identification byte wrong");
	property p_rsvd;
		rd_tk && (ptr inside {7'h05, 7'h07, 7'h09} || ptr > 7'h0a) |=> rd_data == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved location not zero");
	property p_rsvd_bits; rd_tk && ptr == 7'h0a |=> rd_data[7:4] == 4'h0; endproperty
	a_rsvd_bits: assert property (p_rsvd_bits)
		else $error("reserved tristate bits not zero");
	property p_cp_off;
		!cp_mode |-> !bandgap_pd && core_clk_en && pair_clk_en == 4'hf && serial_data_output_oe == 4'hf
			&& chan_zero == 8'h00 && hpf_freeze == 8'h00;
	endproperty
	a_cp_off: assert property (p_cp_off)
		else $error("stand-alone controls wrong");
	property p_pair_zero;
		(chan_zero | {{2{pair_clk_en[3]}}, {2{pair_clk_en[2]}}, {2{pair_clk_en[1]}},
			{2{pair_clk_en[0]}}}) == 8'hff;
	endproperty
	a_pair_zero: assert property (p_pair_zero)
		else $error("stopped pair not zeroed");
	property p_straps;
		(!cp_mode && $stable(strap)) [*8] |-> cfg.fmt == strap.serial_format_select
			&& cfg.mode == strap.mode && cfg.ratio_384 == strap.clock_ratio_select
			&& cfg.div == DIVS[{strap.clock_ratio_select, strap.master_clock_divider}];
	endproperty
	a_straps: assert property (p_straps)
		else $error("strap config not followed");
	property p_ovf_pin;
		cp_mode && (|(ovf_event & mask)) && !host_req.data_wr |-> ##2 overflow_status_pin_oe;
	endproperty
	a_ovf_pin: assert property (p_ovf_pin)
		else $error("overflow pin not pulled");
	// ****************
	// covers
	// ****************
	c_stat_rd: cover property (rd_tk && ptr == 7'h02);
	c_pin: cover property (overflow_status_pin_oe);
	c_cp_off: cover property ($fell(cp_mode));
endmodule

// >>> bench/acrb_host_model.sv
// host model issuing pointer, write and read strobes to the bank
module acrb_host_model
	import acrb_pkg::*;
(
	input  wire logic                     ref_clk,  // core clock
	output acrb_pkg::acrb_host_req_t      host_req, // byte strobes
	input  wire logic [7:0]               rd_data,  // read byte
	input  wire logic                     rd_valid  // read answer
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		host_req = '0;
	end
	// strobe held one edge; idle data flips so stale bytes are never reused
	task automatic send(input logic [2:0] kind, input logic [7:0] b);
		@(posedge ref_clk);
		#1;
		host_req = {kind, b};
		@(posedge ref_clk);
		#1;
		host_req = {3'b000, ~b};
	endtask
	task automatic point(input logic pointer_auto_increment, input logic [6:0] a);
		send(3'b100, {pointer_auto_increment, a});
	endtask
	task automatic write(input logic [7:0] b);
		send(3'b010, b);
	endtask
	// a missing answer comes back unknown so the caller's compare fails
	task automatic read(output logic [7:0] b);
		send(3'b001, 8'h00);
		b = (rd_valid === 1'b1) ? rd_data : 8'hxx;
	endtask
endmodule

// >>> bench/acrb_regs_tb_top.sv
// self-checking bench of the converter control bank
module acrb_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import acrb_pkg::*;
	localparam logic [3:0] PID = 4'h5; // arbitrary value
	localparam logic [3:0] REV = 4'h3; // arbitrary value
	localparam logic [7:0] IDV = {PID, REV};
	localparam acrb_div_t DIVS [8] = '{ACRB_DIV_1, ACRB_DIV_2, ACRB_DIV_2, ACRB_DIV_4,
		ACRB_DIV_1P5, ACRB_DIV_3, ACRB_DIV_3, ACRB_DIV_RSVD};
	localparam logic [7:0] RST_EXP [12] = '{IDV, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] FF_EXP [12] = '{IDV, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
		8'h3f, 8'h00, 8'hff, 8'h00, 8'h0f, 8'h00};
	logic           ref_clk = 1'b0;
	logic           rst = 1'b1;
	acrb_host_req_t host_req;
	logic [7:0]     rd_data;
	logic           rd_valid;
	acrb_strap_t    strap = 7'h5b;
	logic [7:0]     ovf_event = 8'h00;
	acrb_cfg_t      cfg;
	logic           cp_mode, overflow_status_pin_o, overflow_status_pin_oe, bandgap_pd, core_clk_en;
	logic [3:0]     pair_clk_en, serial_data_output_oe;
	logic [7:0]     chan_zero, hpf_freeze;
	int             mismatches = 0;
	int             tests_run = 0;
	int             cycles = 0;
	always #2.5 ref_clk = ~ref_clk;
	acrb_regs #(.PART_ID(PID), .REVISION(REV)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .host_req(host_req), .rd_data(rd_data),
		.rd_valid(rd_valid), .strap(strap), .ovf_event(ovf_event), .cfg(cfg),
		.cp_mode(cp_mode), .overflow_status_pin_o(overflow_status_pin_o), .overflow_status_pin_oe(overflow_status_pin_oe),
		.bandgap_pd(bandgap_pd), .core_clk_en(core_clk_en), .pair_clk_en(pair_clk_en),
		.chan_zero(chan_zero), .hpf_freeze(hpf_freeze), .serial_data_output_oe(serial_data_output_oe));
	acrb_host_model host_u (
		.ref_clk(ref_clk), .host_req(host_req), .rd_data(rd_data), .rd_valid(rd_valid));
	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic rd(input logic [7:0] want);
		logic [7:0] b;
		host_u.read(b);
		chk(b, want);
	endtask
	// walk the whole map and one place past it
	task automatic dump(input logic [7:0] want [12]);
		host_u.point(1'b1, 7'h00);
		for (int i = 0; i < 12; i++) begin
			rd(want[i]);
		end
	endtask
	task automatic pulse(input logic [7:0] ev);
		@(posedge ref_clk);
		#1;
		ovf_event = ev;
		@(posedge ref_clk);
		#1;
		ovf_event = 8'h00;
	endtask
	// controls trail a write strobe by two edges
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task end_sim;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard, well above the expected run of a few hundred cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (20) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		dump(RST_EXP);
		chk(cfg, {2'b10, 2'b11, DIVS[3'b101], 1'b1});
		chk({cp_mode, bandgap_pd, core_clk_en, pair_clk_en, serial_data_output_oe}, 11'h1ff);
		chk({chan_zero, hpf_freeze}, 16'h0000);
		// every location from 0x01 written, reserved ones and one past the end too
		host_u.point(1'b1, 7'h01);
		repeat (11) host_u.write(8'hff);
		dump(FF_EXP);
		chk({cp_mode, bandgap_pd, core_clk_en, pair_clk_en, serial_data_output_oe}, 11'h600);
		chk({chan_zero, hpf_freeze}, 16'hffff);
		chk(cfg, {2'b11, 2'b11, ACRB_DIV_RSVD, 1'b1});
		host_u.point(1'b1, 7'h06);
		host_u.write(8'h01);
		host_u.write(8'haa);
		host_u.write(8'h80);
		host_u.write(8'haa);
		host_u.write(8'h05);
		// fixed pointer: second write and both reads land on one place
		host_u.point(1'b0, 7'h04);
		host_u.write(8'hff);
		host_u.write(8'h01);
		rd(8'h01);
		rd(8'h01);
		chk({cp_mode, bandgap_pd, core_clk_en, pair_clk_en, serial_data_output_oe}, 11'h5ea);
		chk({chan_zero, hpf_freeze}, 16'h8301);
		// every divider, format and mode code
		host_u.point(1'b0, 7'h01);
		for (int i = 0; i < 8; i++) begin
			host_u.write({1'b1, i[2:0], i[1:0], ~i[1:0]});
			settle();
			chk(cfg, {i[1:0], ~i[1:0], DIVS[i], i[2]});
		end
		host_u.point(1'b0, 7'h03);
		host_u.write(8'hfe);
		pulse(8'h01);
		settle();
		chk(overflow_status_pin_oe, 1'b0);
		pulse(8'h02);
		settle();
		chk(overflow_status_pin_oe, 1'b1);
		host_u.point(1'b0, 7'h02);
		rd(8'hfc);
		rd(8'hff);
		settle();
		chk(overflow_status_pin_oe, 1'b0);
		// an overflow meeting a clearing read must survive it
		fork
			rd(8'hff);
			pulse(8'h04);
		join
		rd(8'hfb);
		host_u.point(1'b0, 7'h01);
		host_u.write(8'h00);
		strap = 7'h34;
		repeat (10) @(posedge ref_clk);
		#1;
		chk(cfg, {2'b01, 2'b00, DIVS[3'b011], 1'b0});
		chk({cp_mode, bandgap_pd, core_clk_en, pair_clk_en, serial_data_output_oe}, 11'h1ff);
		chk({chan_zero, hpf_freeze}, 16'h0000);
		rd(8'h00);
		// upper channels and the pin level, then a reset in mid-run over held flags
		pulse(8'hf8);
		settle();
		chk({overflow_status_pin_oe, overflow_status_pin_o}, 2'b10);
		host_u.point(1'b0, 7'h02);
		rd(8'h07);
		pulse(8'h80);
		rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		dump(RST_EXP);
		chk({overflow_status_pin_oe, cfg}, {1'b0, 2'b01, 2'b00, DIVS[3'b011], 1'b0});
		end_sim();
	end
endmodule

bind acrb_regs acrb_regs_props #(.PART_ID(PART_ID), .REVISION(REVISION)) props_u (
	.ref_clk(ref_clk), .rst(rst), .host_req(host_req), .rd_data(rd_data),
	.rd_valid(rd_valid), .strap(strap), .ovf_event(ovf_event), .cfg(cfg),
	.cp_mode(cp_mode), .overflow_status_pin_o(overflow_status_pin_o), .overflow_status_pin_oe(overflow_status_pin_oe),
	.bandgap_pd(bandgap_pd), .core_clk_en(core_clk_en), .pair_clk_en(pair_clk_en),
	.chan_zero(chan_zero), .hpf_freeze(hpf_freeze), .serial_data_output_oe(serial_data_output_oe));
